/* common/lsfb_pkg.sv */
`default_nettype none
package lsfb_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 128;
  localparam int DATA_BYTES = 16;
  localparam int SIZE_W = 5;
  localparam int ID_W = 8;
  localparam int LINE_BYTES = 64;
  localparam int LINE_OFS_W = 6;
  localparam int LB_ENTRIES = 48;
  localparam int LB_IDX_W = 6;
  localparam int SB_ENTRIES = 32;
  localparam int SB_IDX_W = 5;
  localparam int SB_PTR_W = 6;
  localparam int FB_ENTRIES = 10;
  localparam int FB_CNT_W = 4;
  // split lines alternate these gaps, averaging 4.5 cycles per split load
  localparam int SPLIT_GAP_EVEN = 4;
  localparam int SPLIT_GAP_ODD = 5;
  localparam int PACE_CNT_W = 3;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [SIZE_W-1:0] size;
    logic [ID_W-1:0] id;
  } lsfb_load_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [SIZE_W-1:0] size;
    logic [DATA_W-1:0] data;
  } lsfb_store_t;

  typedef struct packed {
    lsfb_load_t req;
    logic waitOn;
    logic [SB_PTR_W-1:0] waitPtr;
  } lsfb_lbent_t;

  typedef struct packed {
    logic [ID_W-1:0] id;
    logic [DATA_W-1:0] data;
    logic forwarded;
  } lsfb_result_t;

  typedef struct packed {
    logic [ID_W-1:0] id;
    logic [DATA_W-1:0] data;
  } lsfb_cache_rsp_t;

  typedef enum logic [1:0] {
    PACE_IDLE = 2'b01,
    PACE_GAP = 2'b10
  } lsfb_pace_t;
endpackage
`default_nettype wire

/* rtl/lsfb_ram.sv */
`timescale 1ns/1ns
`default_nettype none
module lsfb_ram
  import lsfb_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // write side
  input wire logic wrEn,
  input wire logic [LB_IDX_W-1:0] wrAddr,
  input wire lsfb_lbent_t wrData,
  // read side, data registered
  input wire logic [LB_IDX_W-1:0] rdAddr,
  output lsfb_lbent_t rdData
);
  lsfb_lbent_t mem [LB_ENTRIES];
  lsfb_lbent_t rdData_r;

  assign rdData = rdData_r;

  always_ff @(posedge ref_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // write-first so a push into an empty queue is visible at the head next cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdData_r <= '0;
    end else if (wrEn && wrAddr == rdAddr) begin
      rdData_r <= wrData;
    end else begin
      rdData_r <= mem[rdAddr];
    end
  end
endmodule
`default_nettype wire

/* rtl/lsfb_split_pacer.sv */
`timescale 1ns/1ns
`default_nettype none
module lsfb_split_pacer
  import lsfb_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // issue event
  input wire logic start,
  input wire logic split,
  // hold off further issue
  output logic busy
);
  lsfb_pace_t state_r;
  logic [PACE_CNT_W-1:0] cnt_r;
  logic oddTurn_r;

  assign busy = (state_r == PACE_GAP);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= PACE_IDLE;
      cnt_r <= '0;
      oddTurn_r <= 1'b0;
    end else begin
      case (state_r)
        PACE_IDLE: begin
          if (start && split) begin
            state_r <= PACE_GAP;
            oddTurn_r <= !oddTurn_r;
            cnt_r <= oddTurn_r ? PACE_CNT_W'(SPLIT_GAP_ODD - 1) : PACE_CNT_W'(SPLIT_GAP_EVEN - 1);
          end
        end
        PACE_GAP: begin
          if (cnt_r == PACE_CNT_W'(1)) begin
            state_r <= PACE_IDLE;
          end
          cnt_r <= cnt_r - PACE_CNT_W'(1);
        end
        default: begin
          state_r <= PACE_IDLE;
          cnt_r <= '0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* rtl/lsfb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// Contract
// - accept one wide load, one store per cycle
// - 48 load, 32 store, 10 fill entries
// - overlapping older store supplies load data directly
// - forward only from youngest older overlapping store
// - store size must cover load size
// - every load byte inside store bytes
// - otherwise load waits, then uses cache
// - forwarding ignores store address alignment
// - aligned cache loads issue every cycle
// - unaligned in-line loads also every cycle
// - line-split loads about one per 4.5 cycles
module lsfb_top
  import lsfb_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // load issue
  input wire logic ldValid,
  input wire lsfb_load_t ldReq,
  output logic ldReady,
  // store issue
  input wire logic stValid,
  input wire lsfb_store_t stReq,
  output logic stReady,
  // load result
  output logic resValid,
  output lsfb_result_t res,
  // cache read request
  output logic cacheRdValid,
  output lsfb_load_t cacheRdReq,
  output logic cacheRdSplit,
  input wire logic cacheRdReady,
  // cache read response
  input wire logic cacheRspValid,
  input wire lsfb_cache_rsp_t cacheRsp,
  // store drain to cache
  output logic stWrValid,
  output lsfb_store_t stWr,
  input wire logic stWrReady
);
  function automatic logic [ADDR_W:0] endAddr(input logic [ADDR_W-1:0] a,
                                               input logic [SIZE_W-1:0] s);
    endAddr = {1'b0, a} + (ADDR_W + 1)'(s);
  endfunction

  function automatic logic overlaps(input lsfb_load_t l, input lsfb_store_t s);
    overlaps = ({1'b0, l.addr} < endAddr(s.addr, s.size)) &&
               ({1'b0, s.addr} < endAddr(l.addr, l.size));
  endfunction

  function automatic logic contains(input lsfb_load_t l, input lsfb_store_t s);
    contains = (l.size <= s.size) && ({1'b0, l.addr} >= {1'b0, s.addr}) &&
               (endAddr(l.addr, l.size) <= endAddr(s.addr, s.size));
  endfunction

  function automatic logic crossesLine(input lsfb_load_t l);
    crossesLine = ({1'b0, l.addr[LINE_OFS_W-1:0]} + (LINE_OFS_W + 1)'(l.size)) >
                  (LINE_OFS_W + 1)'(LINE_BYTES);
  endfunction

  function automatic logic [DATA_W-1:0] extract(input lsfb_load_t l, input lsfb_store_t s);
    logic [3:0] ofs;
    logic [DATA_W-1:0] shifted;
    ofs = l.addr[3:0] - s.addr[3:0];
    shifted = s.data >> {ofs, 3'b000};
    for (int b = 0; b < DATA_BYTES; b++) begin
      if (SIZE_W'(b) >= l.size) begin
        shifted[b*8 +: 8] = 8'h00;
      end
    end
    extract = shifted;
  endfunction

  function automatic logic [LB_IDX_W-1:0] lbNext(input logic [LB_IDX_W-1:0] i);
    lbNext = (i == LB_IDX_W'(LB_ENTRIES - 1)) ? '0 : i + LB_IDX_W'(1);
  endfunction

  // store buffer, oldest at head
  lsfb_store_t sbMem [SB_ENTRIES];
  logic [SB_PTR_W-1:0] sbHead_r;
  logic [SB_PTR_W-1:0] sbTail_r;
  logic [SB_PTR_W-1:0] sbCount;
  logic [SB_PTR_W-1:0] sbCountNxt;
  logic stPush;
  logic sbPop;

  // load buffer queue
  logic [LB_IDX_W-1:0] lbHead_r;
  logic [LB_IDX_W-1:0] lbTail_r;
  logic [LB_IDX_W-1:0] lbCount_r;
  logic [LB_IDX_W-1:0] lbCountNxt;
  logic [LB_IDX_W-1:0] lbRdAddr;
  lsfb_lbent_t lbHeadEnt;
  lsfb_lbent_t lbNewEnt;
  logic lbPush;
  logic lbPop;
  logic lbBlocked;

  // forwarding search
  logic fwdHit;
  logic fwdOk;
  logic [SB_IDX_W-1:0] fwdIdx;
  logic [SB_IDX_W-1:0] bestRel;
  logic [SB_IDX_W-1:0] rel;
  logic [SB_PTR_W-1:0] youngestPtr;

  // output and holding registers
  logic ldReady_r;
  logic stReady_r;
  logic resValid_r;
  lsfb_result_t res_r;
  logic holdValid_r;
  logic holdNxt;
  lsfb_result_t hold_r;
  logic ldAccept;
  logic fwdTake;
  logic holdEmit;
  logic cacheRdValid_r;
  lsfb_load_t cacheRdReq_r;
  logic cacheRdSplit_r;
  logic stWrValid_r;
  lsfb_store_t stWr_r;
  logic [FB_CNT_W-1:0] fillCnt_r;
  logic rdIssue;
  logic rdFree;
  logic paceBusy;
  logic [LB_IDX_W:0] lbUsedNxt;

  assign ldReady = ldReady_r;
  assign stReady = stReady_r;
  assign resValid = resValid_r;
  assign res = res_r;
  assign cacheRdValid = cacheRdValid_r;
  assign cacheRdReq = cacheRdReq_r;
  assign cacheRdSplit = cacheRdSplit_r;
  assign stWrValid = stWrValid_r;
  assign stWr = stWr_r;

  // one load and one store per cycle
  assign ldAccept = ldValid && ldReady_r;
  assign stPush = stValid && stReady_r;
  assign sbPop = stWrValid_r && stWrReady;
  assign sbCount = sbTail_r - sbHead_r;
  assign sbCountNxt = sbCount + SB_PTR_W'(stPush) - SB_PTR_W'(sbPop);

  always_comb begin
    fwdHit = 1'b0;
    fwdIdx = '0;
    bestRel = '0;
    rel = '0;
    for (int i = 0; i < SB_ENTRIES; i++) begin
      rel = SB_IDX_W'(i) - sbHead_r[SB_IDX_W-1:0];
      if (({1'b0, rel} < sbCount) && overlaps(ldReq, sbMem[i]) &&
          (!fwdHit || rel >= bestRel)) begin
        fwdHit = 1'b1;
        bestRel = rel;
        fwdIdx = SB_IDX_W'(i);
      end
    end
    fwdOk = fwdHit && contains(ldReq, sbMem[fwdIdx]);
    youngestPtr = sbHead_r + {1'b0, bestRel};
  end

  assign fwdTake = ldAccept && fwdOk;
  assign holdEmit = holdValid_r && !cacheRspValid;
  assign holdNxt = fwdTake || (holdValid_r && !holdEmit);

  // forwarded data from the store entry
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      holdValid_r <= 1'b0;
      hold_r <= '0;
    end else begin
      holdValid_r <= holdNxt;
      if (fwdTake) begin
        hold_r <= '{id: ldReq.id, data: extract(ldReq, sbMem[fwdIdx]), forwarded: 1'b1};
      end
    end
  end

  // cache answers win the result port; a forwarded load waits for a cycle with no cache answer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      resValid_r <= 1'b0;
      res_r <= '0;
    end else begin
      resValid_r <= cacheRspValid || holdValid_r;
      if (cacheRspValid) begin
        res_r <= '{id: cacheRsp.id, data: cacheRsp.data, forwarded: 1'b0};
      end else if (holdValid_r) begin
        res_r <= hold_r;
      end
    end
  end

  // non-forwardable loads queue for the cache
  assign lbPush = ldAccept && !fwdOk;
  assign lbNewEnt = '{req: ldReq, waitOn: fwdHit, waitPtr: youngestPtr};
  assign lbRdAddr = lbPop ? lbNext(lbHead_r) : lbHead_r;
  assign lbCountNxt = lbCount_r + LB_IDX_W'(lbPush) - LB_IDX_W'(lbPop);

  lsfb_ram loadQueue (
    .ref_clk(ref_clk),
    .rst(rst),
    .wrEn(lbPush),
    .wrAddr(lbTail_r),
    .wrData(lbNewEnt),
    .rdAddr(lbRdAddr),
    .rdData(lbHeadEnt)
  );

  // wait until the conflicting store has drained
  assign lbBlocked = lbHeadEnt.waitOn && ((lbHeadEnt.waitPtr - sbHead_r) < sbCount);
  assign rdFree = !cacheRdValid_r || cacheRdReady;
  assign rdIssue = (lbCount_r != '0) && !lbBlocked && !paceBusy && rdFree &&
                   (fillCnt_r < FB_CNT_W'(FB_ENTRIES));
  assign lbPop = rdIssue;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lbHead_r <= '0;
      lbTail_r <= '0;
      lbCount_r <= '0;
    end else begin
      lbCount_r <= lbCountNxt;
      if (lbPush) begin
        lbTail_r <= lbNext(lbTail_r);
      end
      if (lbPop) begin
        lbHead_r <= lbNext(lbHead_r);
      end
    end
  end

  lsfb_split_pacer pacer (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(rdIssue),
    .split(crossesLine(lbHeadEnt.req)),
    .busy(paceBusy)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cacheRdValid_r <= 1'b0;
      cacheRdReq_r <= '0;
      cacheRdSplit_r <= 1'b0;
    end else if (rdIssue) begin
      cacheRdValid_r <= 1'b1;
      cacheRdReq_r <= lbHeadEnt.req;
      cacheRdSplit_r <= crossesLine(lbHeadEnt.req);
    end else if (cacheRdReady) begin
      cacheRdValid_r <= 1'b0;
    end
  end

  // fill entries bound outstanding cache reads
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fillCnt_r <= '0;
    end else begin
      fillCnt_r <= fillCnt_r + FB_CNT_W'(rdIssue) - FB_CNT_W'(cacheRspValid);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (stPush) begin
      sbMem[sbTail_r[SB_IDX_W-1:0]] <= stReq;
    end
  end

  // head stays searchable until the cache takes the write
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sbHead_r <= '0;
      sbTail_r <= '0;
      stWrValid_r <= 1'b0;
      stWr_r <= '0;
    end else begin
      if (stPush) begin
        sbTail_r <= sbTail_r + SB_PTR_W'(1);
      end
      if (sbPop) begin
        sbHead_r <= sbHead_r + SB_PTR_W'(1);
        stWrValid_r <= 1'b0;
      end else if (!stWrValid_r && sbCount != '0) begin
        stWrValid_r <= 1'b1;
        stWr_r <= sbMem[sbHead_r[SB_IDX_W-1:0]];
      end
    end
  end

  // a load sent to the cache keeps its load entry until answered
  assign lbUsedNxt = (LB_IDX_W + 1)'(lbCount_r) + (LB_IDX_W + 1)'(fillCnt_r) +
                     (LB_IDX_W + 1)'(lbPush) - (LB_IDX_W + 1)'(cacheRspValid);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ldReady_r <= 1'b0;
      stReady_r <= 1'b0;
    end else begin
      ldReady_r <= (lbUsedNxt < (LB_IDX_W + 1)'(LB_ENTRIES)) && !holdNxt;
      stReady_r <= sbCountNxt < SB_PTR_W'(SB_ENTRIES);
    end
  end
endmodule
`default_nettype wire

/* testbench/lsfb_props.sv */
`timescale 1ns/1ns
`default_nettype none
module lsfb_props
  import lsfb_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // watched ports
  input wire logic ldReady,
  input wire logic stValid,
  input wire logic stReady,
  input wire logic cacheRdValid,
  input wire lsfb_load_t cacheRdReq,
  input wire logic cacheRdSplit,
  input wire logic cacheRdReady,
  input wire logic cacheRspValid,
  input wire logic stWrValid,
  input wire lsfb_store_t stWr,
  input wire logic stWrReady
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire logic rdTake = cacheRdValid && cacheRdReady;
  logic [4:0] fillCnt_r;
  logic [5:0] stCnt_r;
  always_ff @(posedge ref_clk) begin
    if (rst) fillCnt_r <= '0;
    else fillCnt_r <= fillCnt_r + 5'(rdTake) - 5'(cacheRspValid);
  end
  always_ff @(posedge ref_clk) begin
    if (rst) stCnt_r <= '0;
    else stCnt_r <= stCnt_r + 6'(stValid && stReady) - 6'(stWrValid && stWrReady);
  end
  sequence s_split_take;
    rdTake && cacheRdSplit;
  endsequence
  sequence s_no_take3;
    !rdTake [*3];
  endsequence
  a_split_gap: assert property (s_split_take |=> s_no_take3)
    else $error("split issue followed too soon");
  a_split_flag: assert property (cacheRdValid |-> cacheRdSplit ==
    (7'(cacheRdReq.addr[5:0]) + 7'(cacheRdReq.size) > 7'h40))
    else $error("split flag wrong");
  a_rdreq_hold: assert property (cacheRdValid && !cacheRdReady |=>
    cacheRdValid && $stable(cacheRdReq))
    else $error("cache request dropped");
  a_stwr_hold: assert property (stWrValid && !stWrReady |=> stWrValid && $stable(stWr))
    else $error("store drain dropped");
  a_stwr_bubble: assert property (stWrValid && stWrReady |=> !stWrValid)
    else $error("no bubble after drain");
  a_stwr_prompt: assert property (stValid && stReady && stCnt_r == 6'h0 |-> ##2 stWrValid)
    else $error("drain late");
  a_fill_limit: assert property (fillCnt_r <= 5'hA)
    else $error("too many cache reads");
  a_store_limit: assert property (stCnt_r <= 6'h20)
    else $error("too many stores held");
  a_ready_rst: assert property ($fell(rst) |=> ldReady && stReady)
    else $error("ready missing after reset");
endmodule
bind lsfb_top lsfb_props u_lsfb_props (.ref_clk, .rst, .ldReady, .stValid, .stReady,
  .cacheRdValid, .cacheRdReq, .cacheRdSplit, .cacheRdReady, .cacheRspValid, .stWrValid,
  .stWr, .stWrReady);
`default_nettype wire

/* testbench/lsfb_cache_model.sv */
`timescale 1ns/1ns
`default_nettype none
module lsfb_cache_model
  import lsfb_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // slow-cache controls
  input wire logic stall,
  input wire logic holdRsp,
  // cache side
  input wire logic cacheRdValid,
  input wire lsfb_load_t cacheRdReq,
  output logic cacheRdReady,
  output logic cacheRspValid,
  output lsfb_cache_rsp_t cacheRsp,
  input wire logic stWrValid,
  input wire lsfb_store_t stWr,
  output logic stWrReady
);
  lsfb_load_t pend[$];
  int ago[$];
  lsfb_store_t drained[$];
  int cyc = 0;
  initial begin
    cacheRdReady = 1'b0;
    cacheRspValid = 1'b0;
    cacheRsp = '0;
    stWrReady = 1'b0;
  end
  always @(posedge ref_clk) begin
    cyc++;
    cacheRspValid <= 1'b0;
    // idle data toggles so a stale value is never mistaken for a reply
    cacheRsp <= ~cacheRsp;
    if (cacheRdValid && cacheRdReady) begin
      pend.push_back(cacheRdReq);
      ago.push_back(cyc);
    end
    if (!holdRsp && pend.size() > 0 && cyc - ago[0] > 2) begin
      cacheRspValid <= 1'b1;
      cacheRsp <= {pend[0].id, {4{pend[0].addr}}};
      pend.delete(0);
      ago.delete(0);
    end
    if (stWrValid && stWrReady) drained.push_back(stWr);
    cacheRdReady <= !stall && !rst;
    stWrReady <= !stall && !rst;
  end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import lsfb_pkg::*;
;
  localparam logic [127:0] D1 = 128'h00112233445566778899AABBCCDDEEFF;
  localparam logic [127:0] D2 = 128'hF0E1D2C3B4A5968778695A4B3C2D1E0F;
  logic ref_clk = 1'b0, rst = 1'b1, ldValid = 1'b0, stValid = 1'b0;
  logic stall = 1'b0, holdRsp = 1'b0;
  lsfb_load_t ldReq = '0, cacheRdReq;
  lsfb_store_t stReq = '0, stWr;
  logic ldReady, stReady, resValid, cacheRdValid, cacheRdSplit, cacheRdReady;
  logic cacheRspValid, stWrValid, stWrReady;
  lsfb_result_t res;
  lsfb_cache_rsp_t cacheRsp;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  int rdAt[$];
  lsfb_result_t got[$];
  lsfb_top u_lsfb_top (.ref_clk, .rst, .ldValid, .ldReq, .ldReady, .stValid, .stReq,
    .stReady, .resValid, .res, .cacheRdValid, .cacheRdReq, .cacheRdSplit, .cacheRdReady,
    .cacheRspValid, .cacheRsp, .stWrValid, .stWr, .stWrReady);
  lsfb_cache_model u_lsfb_cache_model (.ref_clk, .rst, .stall, .holdRsp, .cacheRdValid,
    .cacheRdReq, .cacheRdReady, .cacheRspValid, .cacheRsp, .stWrValid, .stWr, .stWrReady);
  initial forever #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cacheRdValid && cacheRdReady) rdAt.push_back(cyc);
    if (resValid) got.push_back(res);
    if (cyc > 5000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic check(string name, logic [127:0] seen, logic [127:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic put_store(logic [31:0] a, logic [4:0] s, logic [127:0] d);
    stValid <= 1'b1;
    stReq <= '{a, s, d};
    do @(posedge ref_clk); while (!stReady);
  endtask
  // offers loads for at most cap edges, so a refusing block cannot hang it
  task automatic stream(logic [31:0] a, logic [4:0] s, int n, int cap, output int k);
    k = 0;
    rdAt.delete();
    ldValid <= 1'b1;
    ldReq <= '{a, s, 8'h0};
    while (k < n && cap-- > 0) begin
      @(posedge ref_clk);
      if (ldReady) k++;
      ldReq <= '{a, s, 8'(k)};
    end
    ldValid <= 1'b0;
  endtask
  task automatic get_res(logic [7:0] id, output lsfb_result_t r);
    forever begin
      @(posedge ref_clk);
      foreach (got[i]) if (got[i].id === id) begin
        r = got[i];
        got.delete(i);
        return;
      end
    end
  endtask
  task automatic sc_forward();
    logic [31:0] la[4] = '{32'h107, 32'h103, 32'h10B, 32'h200};
    logic [4:0] ls[4] = '{5'h08, 5'h10, 5'h10, 5'h08};
    lsfb_result_t r;
    int k;
    // the stall keeps the cache shut, so early results can only be forwarded
    stall <= 1'b1;
    put_store(32'h103, 5'h10, D1);
    put_store(32'h103, 5'h10, D2);
    put_store(32'h200, 5'h04, D1);
    stValid <= 1'b0;
    // the last two loads overlap held stores without being contained, so both must wait
    for (int i = 0; i < 4; i++) begin
      stream(la[i], ls[i], 1, 100, k);
      if (i == 3) stall <= 1'b0;
      if (i == 2) @(posedge ref_clk);
      else for (int j = (i == 3) ? 2 : i; j <= i; j++) begin
        get_res(8'h0, r);
        check("fwd flag", 128'(r.forwarded), 128'(j < 2));
        check("ld data", r.data, j < 2 ? (D2 >> (8 * (la[j] - 32'h103))) &
          ({128{1'b1}} >> (8 * (16 - ls[j]))) : {4{la[j]}});
      end
    end
  endtask
  task automatic sc_rate(logic [31:0] a, int n, int g0, int g1);
    int k;
    stream(a, 5'h10, n, 100, k);
    while (rdAt.size() < n || got.size() < n) @(posedge ref_clk);
    for (int i = 1; i < n; i++)
      check("issue gap", 128'(rdAt[i] - rdAt[i-1]), 128'(i % 2 ? g0 : g1));
    got.delete();
  endtask
  task automatic sc_full();
    int k;
    holdRsp <= 1'b1;
    stream(32'h3000, 5'h08, 60, 80, k);
    check("loads held", 128'(k), 128'd48);
    check("reads out", 128'(rdAt.size()), 128'd10);
    holdRsp <= 1'b0;
    while (got.size() < 48) @(posedge ref_clk);
    got.delete();
  endtask
  task automatic sc_stfull();
    int k = 0;
    stall <= 1'b1;
    stValid <= 1'b1;
    stReq <= '{32'h2000, 5'h10, 128'h0};
    repeat (50) begin
      @(posedge ref_clk);
      if (stReady) k++;
      stReq <= '{32'h2000 + 32'(k * 16), 5'h10, 128'(k)};
    end
    check("stores held", 128'(k), 128'd32);
    stall <= 1'b0;
    do @(posedge ref_clk); while (!stReady);
    stValid <= 1'b0;
    while (u_lsfb_cache_model.drained.size() < 36) @(posedge ref_clk);
    for (int i = 0; i < 33; i++)
      check("drain order", u_lsfb_cache_model.drained[i + 3].data, 128'(i));
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    sc_forward();
    sc_rate(32'h1000, 8, 1, 1);
    sc_rate(32'h1004, 8, 1, 1);
    sc_rate(32'h103C, 4, 4, 5);
    sc_full();
    sc_stfull();
    end_of_test();
  end
endmodule
`default_nettype wire
